// File: verilog/excitation_routing_config_i2c_target.v
// i2c target holding the excitation source routing and magnitude registers
`timescale 1ns/1ps
`default_nettype none
`include "excitation_routing_map.vh"

module excitation_routing_config_i2c_target (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        sclIn,
    input  wire        sdaIn,
    output wire        sdaOut,
    output wire        sdaOe,
    input  wire [1:0]  addrStrapLow,
    input  wire [1:0]  addrStrapHigh,
    input  wire        conversionReady,
    output wire        conversionReadyOut,
    output wire        conversionReadyOutOe,
    output wire [2:0]  firstSourceRouteSel,
    output wire [2:0]  secondSourceRouteSel,
    output wire [2:0]  excitationMagnitudeSel,
    output reg         firstSourceOn,
    output reg         secondSourceOn
);

    // ==========================================================
    // states
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_RECV = 5'b00010;
    localparam [4:0] S_ACK  = 5'b00100;
    localparam [4:0] S_SEND = 5'b01000;
    localparam [4:0] S_MACK = 5'b10000;

    // ==========================================================
    // declarations
    wire [`SYNC_WIDTH-1:0] pinSync;
    wire       sclS;
    wire       sdaS;
    wire [6:0] myAddr;
    wire       sclRise;
    wire       sclFall;
    wire       startSeen;
    wire       stopSeen;
    reg        sclPrevReg;
    reg        sdaPrevReg;
    reg  [4:0] stateReg;
    reg  [7:0] shiftReg;
    reg  [3:0] bitCntReg;
    reg  [1:0] byteIdxReg;
    reg        readReg;
    reg        ackSeenReg;
    reg  [7:0] ptrReg;
    reg  [7:0] ptrNext;
    reg  [7:0] routingReg;
    reg  [2:0] magnitudeReg;
    reg        sdaLowReg;
    reg        readyLowReg;
    reg  [7:0] loadByte;

    // ==========================================================
    // register read decode, used on address ack and on each further read byte
    function [7:0] read_data;
        input [7:0] ptr;
        input [7:0] routing;
        input [2:0] magnitude;
        begin
            case (ptr)
                `REG_MAGNITUDE: read_data = {5'h00, magnitude};
                `REG_ROUTING:   read_data = {routing[7:2], `RESERVED_ZERO};
                default:        read_data = 8'h00;
            endcase
        end
    endfunction

    // ==========================================================
    // pin synchronisers: scl, sda and the four strap bits
    i2c_pin_sync u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pinIn   ({addrStrapHigh, addrStrapLow, sdaIn, sclIn}),
        .pinSync (pinSync)
    );

    assign sclS = pinSync[0];
    assign sdaS = pinSync[1];

    // strap address
    // two 2-bit strap codes give 16 addresses under a fixed upper part
    assign myAddr = {`TARGET_ADDR_BASE, pinSync[5:2]};

    // edge and condition detect, only on synchronised copies
    assign sclRise   = sclS & ~sclPrevReg;
    assign sclFall   = ~sclS & sclPrevReg;
    assign startSeen = sclS & sclPrevReg & sdaPrevReg & ~sdaS;
    assign stopSeen  = sclS & sclPrevReg & ~sdaPrevReg & sdaS;

    // ==========================================================
    // previous levels for edge detection
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sclPrevReg <= 1'b1;
            sdaPrevReg <= 1'b1;
        end else begin
            sclPrevReg <= sclS;
            sdaPrevReg <= sdaS;
        end
    end

    // pointer for the next register byte, advanced once per written or sent byte
    always @* begin
        ptrNext = ptrReg + 8'h01;
    end

    // byte to present when a read byte starts
    always @* begin
        loadByte = read_data(ptrReg, routingReg, magnitudeReg);
    end

    // ==========================================================
    // protocol engine
    // all speed modes
    // sampling at 5 ns leaves wide margin even at fast-plus clock rates
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stateReg     <= S_IDLE;
            shiftReg     <= 8'h00;
            bitCntReg    <= 4'h0;
            byteIdxReg   <= 2'h0;
            readReg      <= 1'b0;
            ackSeenReg   <= 1'b0;
            ptrReg       <= 8'h00;
            routingReg   <= `ROUTING_RESET;
            magnitudeReg <= `MAGNITUDE_RESET;
            sdaLowReg    <= 1'b0;
        end else if (startSeen) begin
            // repeated start restarts address phase, pointer kept
            stateReg   <= S_RECV;
            bitCntReg  <= 4'h0;
            byteIdxReg <= 2'h0;
            sdaLowReg  <= 1'b0;
        end else if (stopSeen) begin
            stateReg  <= S_IDLE;
            sdaLowReg <= 1'b0;
        end else begin
            case (stateReg)
                S_IDLE: begin
                    sdaLowReg <= 1'b0;
                end
                S_RECV: begin
                    if (sclRise && bitCntReg != `BITS_PER_BYTE) begin
                        shiftReg  <= {shiftReg[6:0], sdaS};
                        bitCntReg <= bitCntReg + 4'h1;
                    end else if (sclFall && bitCntReg == `BITS_PER_BYTE) begin
                        if (byteIdxReg == 2'h0) begin
                            // foreign address: stay off the bus until next start
                            if (shiftReg[7:1] == myAddr) begin
                                readReg   <= shiftReg[0];
                                sdaLowReg <= 1'b1;
                                stateReg  <= S_ACK;
                            end else begin
                                stateReg <= S_IDLE;
                            end
                        end else if (byteIdxReg == 2'h1) begin
                            ptrReg    <= shiftReg;
                            sdaLowReg <= 1'b1;
                            stateReg  <= S_ACK;
                        end else begin
                            if (ptrReg == `REG_ROUTING) begin
                                routingReg[`FIRST_SEL_MSB:`FIRST_SEL_LSB] <=
                                    shiftReg[`FIRST_SEL_MSB:`FIRST_SEL_LSB];
                                routingReg[`SECOND_SEL_MSB:`SECOND_SEL_LSB] <=
                                    shiftReg[`SECOND_SEL_MSB:`SECOND_SEL_LSB];
                                routingReg[`RESERVED_MSB:`RESERVED_LSB] <= `RESERVED_ZERO;
                            end else if (ptrReg == `REG_MAGNITUDE) begin
                                magnitudeReg <= shiftReg[2:0];
                            end
                            ptrReg    <= ptrNext;
                            sdaLowReg <= 1'b1;
                            stateReg  <= S_ACK;
                        end
                    end
                end
                S_ACK: begin
                    // ack bit ends on the falling clock edge
                    if (sclFall) begin
                        bitCntReg <= 4'h0;
                        if (byteIdxReg != 2'h2) begin
                            byteIdxReg <= byteIdxReg + 2'h1;
                        end
                        if (byteIdxReg == 2'h0 && readReg) begin
                            shiftReg  <= loadByte;
                            sdaLowReg <= ~loadByte[7];
                            stateReg  <= S_SEND;
                        end else begin
                            sdaLowReg <= 1'b0;
                            stateReg  <= S_RECV;
                        end
                    end
                end
                S_SEND: begin
                    if (sclFall) begin
                        if (bitCntReg == `LAST_SEND_BIT) begin
                            sdaLowReg <= 1'b0;
                            ptrReg    <= ptrNext;
                            stateReg  <= S_MACK;
                        end else begin
                            shiftReg  <= {shiftReg[6:0], 1'b0};
                            sdaLowReg <= ~shiftReg[6];
                            bitCntReg <= bitCntReg + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    // controller ack keeps the read going, nack ends it
                    if (sclRise) begin
                        ackSeenReg <= ~sdaS;
                    end else if (sclFall) begin
                        if (ackSeenReg) begin
                            shiftReg  <= loadByte;
                            sdaLowReg <= ~loadByte[7];
                            bitCntReg <= 4'h0;
                            stateReg  <= S_SEND;
                        end else begin
                            stateReg <= S_IDLE;
                        end
                    end
                end
                default: begin
                    stateReg  <= S_IDLE;
                    sdaLowReg <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // open-drain data line: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOe  = sdaLowReg;

    // no clock stretch
    // the clock pin is input only, so the bus clock is never held low

    // ==========================================================
    // conversion ready pin, registered from the conversion logic
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            readyLowReg <= 1'b0;
        end else begin
            readyLowReg <= conversionReady;
        end
    end

    // open-drain ready
    // pulled low while a result waits, external pull-up gives high
    assign conversionReadyOut   = 1'b0;
    assign conversionReadyOutOe = readyLowReg;

    // ==========================================================
    // routing outputs to the analog switches
    assign firstSourceRouteSel    = routingReg[`FIRST_SEL_MSB:`FIRST_SEL_LSB];
    assign secondSourceRouteSel   = routingReg[`SECOND_SEL_MSB:`SECOND_SEL_LSB];
    assign excitationMagnitudeSel = magnitudeReg;

    // source live only with nonzero magnitude and a valid route
    // magnitude gates both
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            firstSourceOn  <= 1'b0;
            secondSourceOn <= 1'b0;
        end else begin
            firstSourceOn  <= (magnitudeReg != `MAGNITUDE_OFF) &&
                              (firstSourceRouteSel != `ROUTE_OFF) &&
                              (firstSourceRouteSel != `ROUTE_RESERVED);
            secondSourceOn <= (magnitudeReg != `MAGNITUDE_OFF) &&
                              (secondSourceRouteSel != `ROUTE_OFF) &&
                              (secondSourceRouteSel != `ROUTE_RESERVED);
        end
    end

endmodule
`default_nettype wire

// File: verilog/excitation_routing_map.vh
// register map, field positions and bus constants for the excitation routing target
`ifndef EXCITATION_ROUTING_MAP_VH
`define EXCITATION_ROUTING_MAP_VH

// ==========================================================
// register pointers
`define REG_MAGNITUDE      8'h02
`define REG_ROUTING        8'h03

// ==========================================================
// reset values
`define ROUTING_RESET      8'h00
`define MAGNITUDE_RESET    3'h0

// ==========================================================
// field positions inside the routing register
`define FIRST_SEL_MSB      7
`define FIRST_SEL_LSB      5
`define SECOND_SEL_MSB     4
`define SECOND_SEL_LSB     2
`define RESERVED_MSB       1
`define RESERVED_LSB       0
`define RESERVED_ZERO      2'h0

// ==========================================================
// route and magnitude codes
`define ROUTE_OFF          3'h0
`define ROUTE_RESERVED     3'h7
`define MAGNITUDE_OFF      3'h0

// ==========================================================
// bus constants
`define TARGET_ADDR_BASE   3'h4
`define BITS_PER_BYTE      4'h8
`define LAST_SEND_BIT      4'h7
`define SYNC_WIDTH         6

`endif

// File: verilog/i2c_pin_sync.v
// two-flop synchronisers for the pins that enter the system clock domain
`timescale 1ns/1ps
`default_nettype none
`include "excitation_routing_map.vh"

module i2c_pin_sync (
    input  wire                     clk_sys,
    input  wire                     rst_n,
    input  wire [`SYNC_WIDTH-1:0]   pinIn,
    output wire [`SYNC_WIDTH-1:0]   pinSync
);

    // ==========================================================
    // per-pin synchroniser chains
    genvar i;
    generate
        for (i = 0; i < `SYNC_WIDTH; i = i + 1) begin : gen_sync
            reg firstReg;
            reg secondReg;
            // idle bus level is high, so reset to high
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    firstReg  <= 1'b1;
                    secondReg <= 1'b1;
                end else begin
                    firstReg  <= pinIn[i];
                    secondReg <= firstReg;
                end
            end
            assign pinSync[i] = secondReg;
        end
    endgenerate

endmodule
`default_nettype wire

// File: bench/excitation_routing_props.sv
// port assertions for the excitation routing target
`timescale 1ns/1ps
`default_nettype none
module excitation_routing_props (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       sclIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       conversionReady,
    input wire logic       conversionReadyOut,
    input wire logic       conversionReadyOutOe,
    input wire logic [2:0] firstSourceRouteSel,
    input wire logic [2:0] secondSourceRouteSel,
    input wire logic [2:0] excitationMagnitudeSel,
    input wire logic       firstSourceOn,
    input wire logic       secondSourceOn
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // pins and bus timing
    pull_low_only_a: assert property (sdaOut == 1'b0 && conversionReadyOut == 1'b0)
        else $error("open-drain pin driven high");
    ready_set_a: assert property (conversionReady |=> conversionReadyOutOe)
        else $error("ready pin not pulled low");
    ready_clear_a: assert property (!conversionReady |=> !conversionReadyOutOe)
        else $error("ready pin not released");
    // ack edges land while the bus clock is low
    ack_rise_a: assert property ($rose(sdaOe) |-> !sclIn)
        else $error("data pulled while clock high");
    ack_fall_a: assert property ($fell(sdaOe) |-> !sclIn)
        else $error("data released while clock high");
    // ==========================================
    // routing and magnitude
    first_on_a: assert property ((excitationMagnitudeSel != 3'h0 && firstSourceRouteSel != 3'h0
        && firstSourceRouteSel != 3'h7) [*2] |-> firstSourceOn) else $error("first source stays off");
    second_on_a: assert property ((excitationMagnitudeSel != 3'h0 && secondSourceRouteSel != 3'h0
        && secondSourceRouteSel != 3'h7) [*2] |-> secondSourceOn) else $error("second source stays off");
    magnitude_off_a: assert property ((excitationMagnitudeSel == 3'h0) [*2]
        |-> !firstSourceOn && !secondSourceOn) else $error("source on with zero magnitude");
    reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0) !rst_n
        |=> firstSourceRouteSel == 3'h0 && secondSourceRouteSel == 3'h0 && !sdaOe && !firstSourceOn)
        else $error("reset leaves state set");
    cover property ($rose(sdaOe));
    cover property (firstSourceOn && secondSourceOn);
    cover property ($rose(conversionReadyOutOe));
endmodule
bind excitation_routing_config_i2c_target excitation_routing_props i_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .conversionReady(conversionReady), .conversionReadyOut(conversionReadyOut),
    .conversionReadyOutOe(conversionReadyOutOe), .firstSourceRouteSel(firstSourceRouteSel),
    .secondSourceRouteSel(secondSourceRouteSel), .excitationMagnitudeSel(excitationMagnitudeSel),
    .firstSourceOn(firstSourceOn), .secondSourceOn(secondSourceOn));
`default_nettype wire

// File: bench/i2c_controller_model.sv
// bus controller model driving clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module i2c_controller_model (
    output logic      scl,
    output logic      sdaLow,
    input  wire logic sda
);
    localparam realtime Q = 31.25;
    logic ackAll;
    // clock idles high between frames
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
        ackAll = 1'b1;
    end
    task automatic xfer(input logic b, output logic r);
        #Q sdaLow = !b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask
    task automatic start();
        #Q sdaLow = 1'b0;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b1;
        #Q scl = 1'b0;
        ackAll = 1'b1;
    endtask
    task automatic stop();
        #Q sdaLow = 1'b1;
        #Q scl = 1'b1;
        #Q sdaLow = 1'b0;
        #Q;
    endtask
    // msb first, ninth slot is ack
    task automatic xbyte(input logic [7:0] d, input logic tail, output logic [7:0] r);
        logic k;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r[i]);
        end
        xfer(tail, k);
        ackAll = ackAll & !k;
    endtask
endmodule
`default_nettype wire

// File: bench/tb_excitation_routing_config_i2c_target.sv
// self-checking bench for the excitation routing target
`timescale 1ns/1ps
`default_nettype none
module tb_excitation_routing_config_i2c_target;
    logic       clk_sys;
    logic       rst_n;
    logic [1:0] addrStrapLow;
    logic [1:0] addrStrapHigh;
    logic       conversionReady;
    wire        scl;
    wire        sdaLow;
    wire        sdaOe;
    wire        sda;
    wire  [2:0] firstSel;
    wire  [2:0] secondSel;
    wire  [2:0] magSel;
    wire        firstOn;
    wire        secondOn;
    logic [7:0] expQ[$];
    logic [7:0] got;
    logic [7:0] e;
    logic [6:0] addr;
    logic [2:0] c3;
    logic [2:0] s3;
    logic [2:0] m;
    int         num_errors = 0;
    int         checked = 0;
    event       gotEv;
    // pull-up on the shared data wire
    assign sda = !(sdaLow | sdaOe);
    excitation_routing_config_i2c_target i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe),
        .addrStrapLow(addrStrapLow), .addrStrapHigh(addrStrapHigh), .conversionReady(conversionReady),
        .conversionReadyOut(), .conversionReadyOutOe(), .firstSourceRouteSel(firstSel),
        .secondSourceRouteSel(secondSel), .excitationMagnitudeSel(magSel), .firstSourceOn(firstOn),
        .secondSourceOn(secondOn));
    i2c_controller_model i_host (.scl(scl), .sdaLow(sdaLow), .sda(sda));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // random ready level, toggled off the sampling edge
    always @(negedge clk_sys) begin
        conversionReady <= 1'($urandom);
    end
    // ==========================================
    // checking side
    always @(gotEv) begin
        e = expQ.pop_front();
        checked++;
        if (got !== e) begin
            num_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, e, got);
        end
    end
    task automatic seen(input logic [7:0] g);
        got = g;
        ->gotEv;
        #1;
    endtask
    task automatic chk(input logic [7:0] x, input logic [7:0] g);
        expQ.push_back(x);
        seen(g);
    endtask
    // ==========================================
    // bus transactions
    task automatic wrReg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d0,
                         input logic [7:0] d1, input logic ok);
        logic [7:0] r;
        expQ.push_back({7'h0, ok});
        // keep bus edges off the sampling edge of the system clock
        @(negedge clk_sys);
        #0.5;
        i_host.start();
        i_host.xbyte({a, 1'b0}, 1'b1, r);
        i_host.xbyte(p, 1'b1, r);
        i_host.xbyte(d0, 1'b1, r);
        i_host.xbyte(d1, 1'b1, r);
        i_host.stop();
        seen({7'h0, i_host.ackAll});
    endtask
    task automatic rdReg(input logic [7:0] p, input logic [7:0] x);
        logic [7:0] r;
        expQ.push_back(x);
        @(negedge clk_sys);
        #0.5;
        i_host.start();
        i_host.xbyte({addr, 1'b0}, 1'b1, r);
        i_host.xbyte(p, 1'b1, r);
        i_host.start();
        i_host.xbyte({addr, 1'b1}, 1'b1, r);
        i_host.xbyte(8'hff, 1'b1, r);
        i_host.stop();
        seen(r);
    endtask
    // two-byte read from the magnitude register on, controller acks the first byte
    task automatic rdPair(input logic [7:0] x0, input logic [7:0] x1);
        logic [7:0] r;
        logic [7:0] r0;
        expQ.push_back(x0);
        expQ.push_back(x1);
        @(negedge clk_sys);
        #0.5;
        i_host.start();
        i_host.xbyte({addr, 1'b0}, 1'b1, r);
        i_host.xbyte(8'h02, 1'b1, r);
        i_host.start();
        i_host.xbyte({addr, 1'b1}, 1'b1, r);
        i_host.xbyte(8'hff, 1'b0, r0);
        i_host.xbyte(8'hff, 1'b1, r);
        i_host.stop();
        seen(r0);
        seen(r);
    endtask
    task automatic report_and_stop();
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog well past the expected run length
    initial begin
        #300000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hd0ae787f));
        rst_n = 1'b0;
        addrStrapLow = 2'h0;
        addrStrapHigh = 2'h0;
        conversionReady = 1'b0;
        addr = 7'h40;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        rdReg(8'h03, 8'h00);
        // every route code on both fields, random straps and magnitude
        for (int c = 0; c < 8; c++) begin
            @(negedge clk_sys);
            addrStrapLow = 2'($urandom);
            addrStrapHigh = 2'($urandom);
            c3 = c[2:0];
            s3 = ~c3;
            m = 3'($urandom);
            repeat (8) @(negedge clk_sys);
            addr = {3'h4, addrStrapHigh, addrStrapLow};
            wrReg(addr ^ 7'h01, 8'h02, 8'h07, 8'h00, 1'b0);
            wrReg(addr, 8'h02, {5'h0, m}, {c3, s3, 2'($urandom)}, 1'b1);
            repeat (8) @(negedge clk_sys);
            chk({c3, s3, 2'h0}, {firstSel, secondSel, 2'h0});
            chk({5'h0, m}, {5'h0, magSel});
            chk({6'h0, m != 0 && c3 != 0 && c3 != 7, m != 0 && s3 != 0 && s3 != 7}, {6'h0, firstOn, secondOn});
            rdReg(8'h03, {c3, s3, 2'h0});
            rdPair({5'h0, m}, {c3, s3, 2'h0});
        end
        wrReg(addr, 8'h05, 8'h5a, 8'ha5, 1'b1);
        rdReg(8'h05, 8'h00);
        // nonzero state so the reset below has something to clear
        wrReg(addr, 8'h02, 8'h07, 8'ha4, 1'b1);
        // second reset in mid-run clears the routing
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk(8'h00, {firstSel, secondSel, magSel[1:0]});
        chk(8'h00, {5'h0, magSel});
        chk(8'h00, {6'h0, firstOn, secondOn});
        rdReg(8'h03, 8'h00);
        rdPair(8'h00, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
